// file: bench/bfit_assertions.sv
/*
  Port checker for the breaker-failure input timer.
  Assumes one clock domain and the 5 ms step of bfit_pkg.
*/
`timescale 1ns/1ns
module bfit_assertions
  import bfit_pkg::*;
(
  // Clock and reset
  input wire logic                 clock_i,
  input wire logic                 rst_b_i,
  // Inputs
  input wire logic                 trip_input_i,
  input wire logic                 block_i,
  input wire logic [1:0]           criterion_i,
  input wire logic                 retrip_en_i,
  input wire logic [DLY_W-1:0]     retrip_steps_i,
  input wire logic [DLY_W-1:0]     fail_steps_i,
  input wire logic [2*NUM_SIG-1:0] event_sel_i,
  // Outputs
  input wire logic                 start_o,
  input wire logic                 repeat_trip_o,
  input wire logic                 breaker_failure_output_o,
  input wire logic                 blocked_o,
  input wire logic [DLY_W-1:0]     failure_time_left_o,
  input wire logic                 event_valid_o,
  input wire logic [EVC_W-1:0]     event_code_o,
  input wire logic [4:0]           rec_fill_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // Cycles of an unbroken run; a step may land anywhere in the first one.
  int unsigned run_q;
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || !start_o) run_q <= 0;
    else run_q <= run_q + 1;
  end

  sequence held_s;
    (trip_input_i && !block_i && criterion_i == 2'h0)[*5];
  endsequence
  sequence gone_s;
    (!trip_input_i && criterion_i == 2'h0)[*5];
  endsequence

  input_start_a: assert property (held_s |-> start_o)
    else $error("start missing after input");
  input_drop_a: assert property (gone_s |-> !start_o &&
    !breaker_failure_output_o) else $error("run kept after input");
  fail_needs_start_a: assert property ($rose(breaker_failure_output_o)
    |-> start_o) else $error("failure trip without start");
  blocked_quiet_a: assert property (blocked_o[*2] |->
    !breaker_failure_output_o && failure_time_left_o == '0)
    else $error("timer runs while blocked");
  idle_left_a: assert property ((!start_o)[*2] |->
    failure_time_left_o == '0 && !repeat_trip_o) else $error("idle not clear");
  fail_early_a: assert property ($rose(breaker_failure_output_o) &&
    fail_steps_i < 19'h100 |-> run_q + STEP_CYCLES + 2 >=
    fail_steps_i * STEP_CYCLES) else $error("failure trip early");
  fail_late_a: assert property (start_o && fail_steps_i < 19'h100 &&
    run_q > fail_steps_i * STEP_CYCLES + 4 |-> breaker_failure_output_o)
    else $error("failure trip late");
  retrip_late_a: assert property (start_o && retrip_en_i &&
    retrip_steps_i < 19'h100 && run_q > retrip_steps_i * STEP_CYCLES + 4
    |-> repeat_trip_o) else $error("repeat trip late");
  start_event_a: assert property ($rose(start_o) && event_sel_i[0]
    |-> ##[0:20] (event_valid_o && event_code_o == 4'h0))
    else $error("start event missing");
  fill_max_a: assert property (rec_fill_o <= 5'd12)
    else $error("too many records");
endmodule // bfit_assertions

bind bfit_top bfit_assertions i_bfit_assertions (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .trip_input_i(trip_input_i),
  .block_i(block_i), .criterion_i(criterion_i), .retrip_en_i(retrip_en_i),
  .retrip_steps_i(retrip_steps_i), .fail_steps_i(fail_steps_i),
  .event_sel_i(event_sel_i), .start_o(start_o),
  .repeat_trip_o(repeat_trip_o),
  .breaker_failure_output_o(breaker_failure_output_o),
  .blocked_o(blocked_o), .failure_time_left_o(failure_time_left_o),
  .event_valid_o(event_valid_o), .event_code_o(event_code_o),
  .rec_fill_o(rec_fill_o)
);

// file: bench/bfit_feeder_model.sv
/*
  Outgoing feeder relay: drives its trip to the unit's input pin.
  Assumes the bench sets the command at the falling edge.
*/
`timescale 1ns/1ns
module bfit_feeder_model (
  // Clock
  input  wire logic       clock_i,
  // Command from the bench
  input  wire logic       cmd_i,
  input  wire logic       contact_en_i,
  input  wire logic [2:0] lag_i,
  // Pins of the failure unit
  output logic            trip_input_o,
  output logic            contact_mon_o
);
  logic [2:0] wait_q;
  initial begin
    trip_input_o = 1'b0;
    wait_q       = 3'h0;
  end
  // A slow relay closes lag_i cycles late; changes land at the edge.
  always @(posedge clock_i) begin
    if (!cmd_i) begin
      wait_q       <= 3'h0;
      trip_input_o <= 1'b0;
    end else if (wait_q != lag_i) begin
      wait_q <= wait_q + 3'h1;
    end else begin
      trip_input_o <= 1'b1;
    end
  end
  assign contact_mon_o = trip_input_o & contact_en_i;
endmodule // bfit_feeder_model

// file: bench/test_breaker_failure_input_timer.sv
/*
  Self-checking bench for the breaker-failure input timer.
  Assumes the design, the feeder model and the checker are compiled first.
*/
`timescale 1ns/1ns
module test_breaker_failure_input_timer;
  import bfit_pkg::*;
  logic             clock_i = 1'b0, rst_b_i = 1'b0, cnt_clear_i = 1'b0;
  logic             cmd = 1'b0, contact_en = 1'b0, block_i = 1'b0, ev_lost;
  logic [2:0]       lag = 3'h0, group_i = 3'h0;
  logic [1:0]       criterion_i = 2'h0;
  logic [15:0]      ev_sel = 16'h0033;
  logic             retrip_en_i = 1'b0, st_exp;
  logic [DLY_W-1:0] retrip_steps_i = '0, fail_steps_i = '0;
  logic [CUR_W-1:0] phase_max_i = '0, res_cur_i = '0;
  logic [TS_W-1:0]  time_ms_i = '0;
  logic             trip_input, contact_mon, start_o, repeat_trip_o;
  logic             breaker_failure_output_o, blocked_o, event_valid_o;
  logic [DLY_W-1:0] failure_time_left_o, rt_left;
  logic [EVC_W-1:0] event_code_o;
  logic [TS_W-1:0]  event_time_o;
  logic [CNT_W-1:0] retrip_count_o, fail_count_o, start_count_o, block_count_o;
  logic [REC_W-1:0] rec_data_o;
  logic [4:0]       rec_fill_o;
  logic [TS_W+EVC_W-1:0] exp_q[$];
  int               n_errors = 0, cmp_count = 0, c, d;
  integer           seed = 32'hb66dfeb3;

  always #50 clock_i = ~clock_i;

  bfit_feeder_model i_bfit_feeder_model (.clock_i(clock_i), .cmd_i(cmd),
    .contact_en_i(contact_en), .lag_i(lag), .trip_input_o(trip_input),
    .contact_mon_o(contact_mon));

  bfit_top i_bfit_top (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .trip_input_i(trip_input), .contact_mon_i(contact_mon), .block_i(block_i),
    .criterion_i(criterion_i), .retrip_en_i(retrip_en_i),
    .retrip_steps_i(retrip_steps_i), .fail_steps_i(fail_steps_i),
    .phase_set_i(16'h1000), .res_set_i(16'h1000), .event_sel_i(ev_sel),
    .group_i(group_i), .phase_max_i(phase_max_i), .res_cur_i(res_cur_i),
    .time_ms_i(time_ms_i), .cnt_clear_i(cnt_clear_i), .rec_idx_i(4'h0),
    .start_o(start_o), .repeat_trip_o(repeat_trip_o),
    .breaker_failure_output_o(breaker_failure_output_o),
    .blocked_o(blocked_o), .repeat_trip_time_left_o(rt_left),
    .failure_time_left_o(failure_time_left_o),
    .event_valid_o(event_valid_o), .event_code_o(event_code_o),
    .event_time_o(event_time_o), .event_lost_o(ev_lost),
    .retrip_count_o(retrip_count_o), .fail_count_o(fail_count_o),
    .start_count_o(start_count_o), .block_count_o(block_count_o),
    .rec_data_o(rec_data_o), .rec_fill_o(rec_fill_o));

  task automatic check(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t ns: %s", $time, what);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic expect_ev(input logic [3:0] code);
    exp_q.push_back({time_ms_i, code});
  endtask

  // One trip from the feeder; st and fl say what the unit must do.
  task automatic pulse(input logic st, input logic fl, input logic hi);
    int i;
    lag = 3'($random(seed));
    group_i = 3'($random(seed));
    time_ms_i = {16'h0, 32'($random(seed))};
    phase_max_i = (16'($random(seed)) & 16'h0fff) | (hi ? 16'hf000 : 16'h0);
    res_cur_i = 16'($random(seed)) & 16'h0fff;
    if (st && ev_sel[0]) expect_ev(4'h0);
    if (st && fl && ev_sel[4]) expect_ev(4'h4);
    cmd = 1'b1;
    repeat (16) @(negedge clock_i);
    for (i = 0; i < 60000 && breaker_failure_output_o !== fl; i++)
      @(negedge clock_i);
    if (i == 60000) begin
      check(1'b0, "failure trip wait ran out");
      print_verdict();
    end
    check(start_o === st, "start");
    check(blocked_o === block_i, "blocked");
    check(repeat_trip_o === (fl & retrip_en_i), "repeat trip");
    check(rec_data_o[GRP_W-1:0] === group_i, "record group");
    check(rec_data_o[REC_W-1 -: TS_W] === time_ms_i, "record time");
    if (st && !fl)
      check(failure_time_left_o inside {[1:fail_steps_i]}, "left");
    if (st && ev_sel[1]) expect_ev(4'h1);
    if (st && fl && ev_sel[5]) expect_ev(4'h5);
    cmd = 1'b0;
    repeat (16) @(negedge clock_i);
    check(!breaker_failure_output_o && failure_time_left_o === '0 &&
          rt_left === '0, "idle");
  endtask

  always @(negedge clock_i) begin
    if (rst_b_i && event_valid_o === 1'b1) begin
      if (exp_q.size() == 0) check(1'b0, "event not selected");
      else check({event_time_o, event_code_o} === exp_q.pop_front(),
                 "event code or stamp");
    end
    if (rst_b_i && ev_lost !== 1'b0) check(1'b0, "event lost");
  end

  initial begin
    repeat (6) @(negedge clock_i);
    rst_b_i = 1'b1;
    for (c = 0; c < 4; c++) begin
      for (d = 0; d < 4; d++) begin
        criterion_i = 2'(c);
        contact_en = d[0];
        st_exp = c == 0 || c == 3 || (c == 1 && d == 3) || (c == 2 && d != 0);
        pulse(st_exp, st_exp, d[1]);
      end
    end
    $display("test criteria done");
    criterion_i = 2'h0;
    block_i = 1'b1;
    pulse(1'b0, 1'b0, 1'b0);
    block_i = 1'b0;
    $display("test block done");
    fail_steps_i = 19'd2;
    pulse(1'b1, 1'b0, 1'b0);
    $display("test early drop done");
    fail_steps_i = 19'd1;
    retrip_steps_i = 19'd1;
    retrip_en_i = 1'b1;
    ev_sel = 16'h0021;
    pulse(1'b1, 1'b1, 1'b0);
    $display("test timed trip done");
    check({start_count_o, fail_count_o, retrip_count_o, block_count_o} ===
          {16'd14, 16'd13, 16'd1, 16'd1}, "counts");
    check(rec_fill_o === 5'd12, "record fill");
    cnt_clear_i = 1'b1;
    repeat (3) @(negedge clock_i);
    cnt_clear_i = 1'b0;
    @(negedge clock_i);
    check({start_count_o, fail_count_o, retrip_count_o, block_count_o} ===
          '0, "cleared counts");
    check(exp_q.size() == 0, "events missing");
    $display("test counters done");
    print_verdict();
  end
endmodule // test_breaker_failure_input_timer

// file: rtl/bfit_delay.sv
/*
  Definite-time delay in step units: counts while start holds.
  Assumes step_i is a one-cycle enable from the parent's divider.
*/
`timescale 1ns/1ns
module bfit_delay
  import bfit_pkg::*;
(
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  // Control
  input  wire logic             start_i,
  input  wire logic             step_i,
  input  wire logic [DLY_W-1:0] delay_i,
  // Result
  output logic                  expired_o,
  output logic      [DLY_W-1:0] left_o
);

  logic [DLY_W-1:0] count_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i || !start_i) begin
      count_reg <= '0;
    end else if (step_i && count_reg < delay_i) begin
      count_reg <= count_reg + DLY_W'(1);
    end
  end

  assign expired_o = start_i && (count_reg >= delay_i);
  assign left_o    = (count_reg >= delay_i) ? '0 : delay_i - count_reg;

endmodule // bfit_delay

// file: rtl/bfit_pkg.sv
/*
  Shared constants and types for the breaker-failure input timer.
  Assumes a 10 MHz clock and a 5 ms delay step derived from it.
*/
package bfit_pkg;

  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned STEP_US     = 5000;
  localparam int unsigned STEP_CYCLES = CLK_HZ / 1_000_000 * STEP_US;
  localparam int unsigned MS_CYCLES   = CLK_HZ / 1000;

  // Delays are counted in 5 ms steps.
  localparam int unsigned DLY_W       = 19;
  localparam int unsigned RETR_MS     = 100;
  localparam int unsigned FAIL_MS     = 200;
  localparam logic [DLY_W-1:0] RETR_DEF_STEPS = DLY_W'(RETR_MS * 1000 / STEP_US);
  localparam logic [DLY_W-1:0] FAIL_DEF_STEPS = DLY_W'(FAIL_MS * 1000 / STEP_US);

  localparam int unsigned NUM_SIG  = 8;
  localparam int unsigned REC_NUM  = 12;
  localparam int unsigned CUR_W    = 16;
  localparam int unsigned TS_W     = 48;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned GRP_W    = 3;
  localparam int unsigned EVC_W    = 4;

  // Signal index of each event source.
  localparam int unsigned SIG_START = 0;
  localparam int unsigned SIG_RETR  = 1;
  localparam int unsigned SIG_FAIL  = 2;
  localparam int unsigned SIG_BLOCK = 3;
  localparam int unsigned SIG_DOMON = 4;
  localparam int unsigned SIG_INPUT = 5;
  localparam int unsigned SIG_PHASE = 6;
  localparam int unsigned SIG_RES   = 7;

  // Event store selection per signal.
  localparam logic [1:0] SEL_ON   = 2'h1;
  localparam logic [1:0] SEL_OFF  = 2'h2;
  localparam logic [1:0] SEL_BOTH = 2'h3;

  // Start criterion combined with the digital input.
  typedef enum logic [1:0] {
    BFIT_CRIT_INPUT,
    BFIT_CRIT_CUR_AND_DO,
    BFIT_CRIT_CUR_OR_DO
  } bfit_crit_t;

  localparam int unsigned REC_W =
    TS_W + EVC_W + 2 * CUR_W + 2 * DLY_W + GRP_W;

endpackage

// file: rtl/bfit_rec_mem.sv
/*
  Ring of the most recent operation records with registered read data.
  Assumes the parent supplies one write strobe per record.
*/
`timescale 1ns/1ns
module bfit_rec_mem
  import bfit_pkg::*;
#(
  parameter int unsigned DEPTH = REC_NUM,
  parameter int unsigned WIDTH = REC_W
) (
  // Clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     rst_b_i,
  // Write side
  input  wire logic                     wr_i,
  input  wire logic [WIDTH-1:0]         wr_data_i,
  // Read side, index 0 is the newest record
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
  output logic      [WIDTH-1:0]         rd_data_o,
  output logic      [$clog2(DEPTH):0]   fill_o
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wp_reg;
  logic [AW:0]      fill_reg;
  logic [AW-1:0]    rd_addr;

  always_ff @(posedge clock_i) begin
    if (wr_i) begin
      mem_reg[wp_reg] <= wr_data_i;
    end
  end

  // The oldest record is overwritten once the ring is full.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wp_reg   <= '0;
      fill_reg <= '0;
    end else if (wr_i) begin
      wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + AW'(1);
      if (fill_reg != (AW+1)'(DEPTH)) begin
        fill_reg <= fill_reg + (AW+1)'(1);
      end
    end
  end

  always_comb begin
    if ({1'b0, wp_reg} > {1'b0, rd_idx_i}) begin
      rd_addr = wp_reg - rd_idx_i - AW'(1);
    end else begin
      rd_addr = AW'(DEPTH - 1) - (rd_idx_i - wp_reg);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem_reg[rd_addr];
    end
  end

  assign fill_o = fill_reg;

endmodule // bfit_rec_mem

// file: rtl/bfit_top.sv
/*
  Breaker-failure input timer run as a dedicated failure unit.
  Assumes the pins arrive asynchronous, measurements and time from logic
  on the same clock, and a 10 MHz clock.
*/
// Contract
// RULE1: Dedicated mode starts supervision only from the digital input state.
// RULE2: The failure delay counter starts when the digital input activates.
// RULE3: Counter still running at the delay asserts the upstream failure trip.
// RULE4: Current and output-contact supervision may still combine with input.
// RULE5: Feeders wire trips to the input; own trip used only for failure.
// RULE6: Separate ON and OFF events for all eight internal signals.
// RULE7: Per-event selection stores ON, OFF or both in the buffer.
// RULE8: Every event carries a time stamp taken at the change.
// RULE9: Clearable cumulative counters for repeat, failure, start, blocked.
// RULE10: Only the twelve most recent operation records are kept.
// RULE11: Records are captured on ON events with process data then present.
// RULE12: Record holds time, event, currents, times left and setting group.
// RULE13: Outputs are available for physical outputs and user logic.
// RULE14: Failure output after start held for the delay; 5 ms steps, 0.2 s.
// RULE15: Repeat trip after start held for its delay; default 0.1 s.
// RULE16: Input dropping before expiry clears the counter; output stays off.
`timescale 1ns/1ns
module bfit_top
  import bfit_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    rst_b_i,
  // Pins from the outgoing feeders and the trip contact monitor
  input  wire logic                    trip_input_i,
  input  wire logic                    contact_mon_i,
  input  wire logic                    block_i,
  // Settings
  input  wire logic [1:0]              criterion_i,
  input  wire logic                    retrip_en_i,
  input  wire logic [DLY_W-1:0]        retrip_steps_i,
  input  wire logic [DLY_W-1:0]        fail_steps_i,
  input  wire logic [CUR_W-1:0]        phase_set_i,
  input  wire logic [CUR_W-1:0]        res_set_i,
  input  wire logic [2*NUM_SIG-1:0]    event_sel_i,
  input  wire logic [GRP_W-1:0]        group_i,
  // Measurements and time base
  input  wire logic [CUR_W-1:0]        phase_max_i,
  input  wire logic [CUR_W-1:0]        res_cur_i,
  input  wire logic [TS_W-1:0]         time_ms_i,
  // Counter clear and record read
  input  wire logic                    cnt_clear_i,
  input  wire logic [3:0]              rec_idx_i,
  // Protection outputs
  output logic                         start_o,
  output logic                         repeat_trip_o,
  output logic                         breaker_failure_output_o,
  output logic                         blocked_o,
  output logic [DLY_W-1:0]             repeat_trip_time_left_o,
  output logic [DLY_W-1:0]             failure_time_left_o,
  // Event stream of the failure_event_block
  output logic                         event_valid_o,
  output logic [EVC_W-1:0]             event_code_o,
  output logic [TS_W-1:0]              event_time_o,
  output logic                         event_lost_o,
  // Counters
  output logic [CNT_W-1:0]             retrip_count_o,
  output logic [CNT_W-1:0]             fail_count_o,
  output logic [CNT_W-1:0]             start_count_o,
  output logic [CNT_W-1:0]             block_count_o,
  // Records
  output logic [REC_W-1:0]             rec_data_o,
  output logic [4:0]                   rec_fill_o
);

  // Step divider: one enable pulse per 5 ms.
  logic [$clog2(STEP_CYCLES)-1:0] div_reg;
  logic                           step;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i || step) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  assign step = (div_reg == ($clog2(STEP_CYCLES))'(STEP_CYCLES - 1));

  // Pin synchronisers, two stages each.
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= {block_i, contact_mon_i, trip_input_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic in_act;
  logic do_act;
  logic blk_act;
  logic ph_act;
  logic res_act;
  logic cur_act;
  logic start_cond;

  assign in_act  = pin_sync_reg[0];
  assign do_act  = pin_sync_reg[1];
  assign blk_act = pin_sync_reg[2];
  assign ph_act  = phase_max_i > phase_set_i;
  assign res_act = res_cur_i > res_set_i;
  assign cur_act = ph_act || res_act;

  // The feeders' trip arrives on the input; no own stage starts the timer.
  always_comb begin // RULE5
    unique case (bfit_crit_t'(criterion_i))
      BFIT_CRIT_INPUT:      start_cond = in_act; // RULE1
      BFIT_CRIT_CUR_AND_DO: start_cond = in_act && cur_act && do_act; // RULE4
      BFIT_CRIT_CUR_OR_DO:  start_cond = in_act && (cur_act || do_act); // RULE4
      default:              start_cond = in_act;
    endcase
  end

  logic run;
  assign run = start_cond && !blk_act;

  logic fail_exp;
  logic retr_exp;
  logic [DLY_W-1:0] fail_left;
  logic [DLY_W-1:0] retr_left;

  // Dropping run clears the count inside the delay module.
  bfit_delay u_fail_dly ( // RULE2 RULE16
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .start_i   (run),
    .step_i    (step),
    .delay_i   (fail_steps_i),
    .expired_o (fail_exp),
    .left_o    (fail_left)
  );

  bfit_delay u_retr_dly (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .start_i   (run && retrip_en_i),
    .step_i    (step),
    .delay_i   (retrip_steps_i),
    .expired_o (retr_exp),
    .left_o    (retr_left)
  );

  // Outputs are registered so they can drive contacts and user logic.
  always_ff @(posedge clock_i) begin // RULE13
    if (!rst_b_i) begin
      start_o                  <= 1'b0;
      repeat_trip_o            <= 1'b0;
      breaker_failure_output_o <= 1'b0;
      blocked_o                <= 1'b0;
      repeat_trip_time_left_o  <= '0;
      failure_time_left_o      <= '0;
    end else begin
      start_o                  <= run;
      repeat_trip_o            <= retr_exp; // RULE15
      breaker_failure_output_o <= fail_exp; // RULE3 RULE14 RULE16
      blocked_o                <= start_cond && blk_act;
      repeat_trip_time_left_o  <= run && retrip_en_i ? retr_left : '0;
      failure_time_left_o      <= run ? fail_left : '0;
    end
  end

  // Edge detection of all eight signals.
  logic [NUM_SIG-1:0] sig_now;
  logic [NUM_SIG-1:0] sig_prev_reg;
  logic [NUM_SIG-1:0] rise;
  logic [NUM_SIG-1:0] fall;

  assign sig_now = {res_act, ph_act, in_act, do_act, blocked_o,
                    breaker_failure_output_o, repeat_trip_o, start_o};

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sig_prev_reg <= '0;
    end else begin
      sig_prev_reg <= sig_now;
    end
  end
  assign rise = sig_now & ~sig_prev_reg; // RULE6
  assign fall = ~sig_now & sig_prev_reg; // RULE6

  // Pending events; a new edge wins over the clear of the one being sent.
  logic [2*NUM_SIG-1:0] pend_reg;
  logic [2*NUM_SIG-1:0] want;
  logic [2*NUM_SIG-1:0] take;
  logic [2*NUM_SIG-1:0] pend_take;
  logic                 any_pend;
  logic [EVC_W-1:0]     pick;

  // Lowest pending index: code is 2*signal, plus one for OFF.
  function automatic logic [EVC_W-1:0] first_set(logic [2*NUM_SIG-1:0] v);
    first_set = '0;
    for (int i = 2 * NUM_SIG - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = EVC_W'(i);
      end
    end
  endfunction

  for (genvar g = 0; g < NUM_SIG; g++) begin : g_sel
    assign want[2*g]   = rise[g] && event_sel_i[2*g]; // RULE7
    assign want[2*g+1] = fall[g] && event_sel_i[2*g+1]; // RULE7
  end

  assign any_pend  = |pend_reg;
  assign pick      = first_set(pend_reg);
  assign take      = any_pend ? ((2*NUM_SIG)'(1) << pick) : '0;
  assign pend_take = pend_reg & ~take;

  // Time stamps are caught at the edge, one per pending event.
  logic [TS_W-1:0] ts_reg [2*NUM_SIG];

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pend_reg     <= '0;
      event_lost_o <= 1'b0;
    end else begin
      pend_reg     <= pend_take | want;
      event_lost_o <= |(want & pend_take);
    end
  end

  for (genvar g = 0; g < 2 * NUM_SIG; g++) begin : g_ts
    always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
        ts_reg[g] <= '0;
      end else if (want[g]) begin
        ts_reg[g] <= time_ms_i; // RULE8
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      event_valid_o <= 1'b0;
      event_code_o  <= '0;
      event_time_o  <= '0;
    end else begin
      event_valid_o <= any_pend;
      event_code_o  <= pick;
      event_time_o  <= ts_reg[pick]; // RULE8
    end
  end

  // Cumulative counters; a clear in the same cycle as an event still counts.
  logic [3:0]       cnt_inc;
  logic [CNT_W-1:0] cnt_reg [4];

  assign cnt_inc = {rise[SIG_BLOCK], rise[SIG_START],
                    rise[SIG_FAIL], rise[SIG_RETR]};

  for (genvar g = 0; g < 4; g++) begin : g_cnt
    always_ff @(posedge clock_i) begin // RULE9
      if (!rst_b_i) begin
        cnt_reg[g] <= '0;
      end else if (cnt_clear_i) begin
        cnt_reg[g] <= cnt_inc[g] ? CNT_W'(1) : '0;
      end else if (cnt_inc[g] && cnt_reg[g] != '1) begin
        cnt_reg[g] <= cnt_reg[g] + CNT_W'(1);
      end
    end
  end

  assign retrip_count_o = cnt_reg[0];
  assign fail_count_o   = cnt_reg[1];
  assign start_count_o  = cnt_reg[2];
  assign block_count_o  = cnt_reg[3];

  // A record for each ON edge; several in one cycle keep the lowest.
  logic             rec_wr;
  logic [EVC_W-1:0] rec_code;
  logic [REC_W-1:0] rec_word;

  assign rec_wr   = |rise; // RULE11
  assign rec_code = first_set({NUM_SIG'(0), rise} << 0);
  assign rec_word = {time_ms_i, rec_code << 1, phase_max_i, res_cur_i,
                     retr_left, fail_left, group_i}; // RULE12

  bfit_rec_mem u_rec ( // RULE10
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .wr_i      (rec_wr),
    .wr_data_i (rec_word),
    .rd_idx_i  (rec_idx_i),
    .rd_data_o (rec_data_o),
    .fill_o    (rec_fill_o)
  );

endmodule // bfit_top
